// file: design/pdr_top.v
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pdr_regs.vh"
// Functional notes
// R01 - sixteen output data bits in high and low bytes drive the pulse pins
// R02 - output data bits with pulse enable set ignore processor writes
// R03 - on selected trigger, enabled next-data bits copy into output data
// R04 - disabled output bits take processor writes to preset initial level
// R05 - output data and next data reset to zero
// R06 - next-data decoding follows whether paired groups share a trigger
// R07 - groups 2,3 same trigger: upper next data at one address
// R08 - groups 2,3 differ: bits 15-12 and 11-8 at two addresses
// R09 - groups 0,1 same trigger: lower next data at one address
// R10 - groups 0,1 differ: bits 7-4 and 3-0 at two addresses
// R11 - unused nibble in split views reads ones, ignores writes
// R12 - each nibble moves only on its own group's selected trigger
// R13 - only bits whose enable is one are ever transferred
// R14 - select codes 00..11 pick compare match of timer channel 0..3
// R15 - enabled bits of a group update together in the trigger cycle
module pdr_top (
    // clock and reset
    input wire CORE_CLK,
    input wire NRST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // compare match pulses, timer channels 0..3
    input wire [3:0] MATCH_PULSE,
    // pulse outputs
    output reg [15:0] PULSE_OUT
);
    reg [15:0] next_data_r;
    reg [15:0] enable_r;
    reg [7:0] ctrl_r;
    wire [15:0] out_data;
    wire wr_acc;
    wire rd_acc;
    wire high_shared;
    wire low_shared;
    reg [31:0] rdata_nxt;
    reg hit_nxt;
    reg [3:0] grp_wr;
    wire [15:0] next_nxt;
    reg [31:0] prdata_nxt;
    reg pready_nxt;
    reg pslverr_nxt;

    // read view of each register, low byte of the word
    wire [7:0] rd_out_high;
    wire [7:0] rd_out_low;
    wire [7:0] rd_next_high;
    wire [7:0] rd_next_high_nib;
    wire [7:0] rd_next_low;
    wire [7:0] rd_next_low_nib;
    wire [7:0] rd_enable_high;
    wire [7:0] rd_enable_low;
    wire [7:0] rd_ctrl;

    // write strobes decoded from the access cycle
    wire out_high_wr;
    wire out_low_wr;
    wire en_high_wr;
    wire en_low_wr;
    wire ctrl_wr;
    wire setup_phase;
    genvar g;
    genvar p;

    // one-wait-free apb: answer in the access cycle itself
    assign wr_acc = PSEL & PENABLE & PWRITE;
    assign rd_acc = PSEL & ~PENABLE & ~PWRITE;

    // a pair shares one window when both groups pick the same channel
    assign high_shared = pair_shared(ctrl_r[7:4]); // R06
    assign low_shared = pair_shared(ctrl_r[3:0]); // R06

    function is_addr;
        input [11:0] a;
        input [11:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // upper code pair against lower code pair
    function pair_shared;
        input [3:0] sel;
        begin
            pair_shared = (sel[3:2] == sel[1:0]);
        end
    endfunction

    // split view, live nibble on top and ones below
    function [7:0] view_upper;
        input [3:0] nib;
        begin
            view_upper = {nib, `PDR_NIB_ONES};
        end
    endfunction

    // split view, ones on top and live nibble below
    function [7:0] view_lower;
        input [3:0] nib;
        begin
            view_lower = {`PDR_NIB_ONES, nib};
        end
    endfunction

    // registers sit in the low byte, upper bits read zero
    function [31:0] pad_byte;
        input [7:0] b;
        begin
            pad_byte = {`PDR_PAD_ZERO, b};
        end
    endfunction

    // merged window or upper-nibble window of one pair
    function [7:0] pair_view;
        input shared;
        input [7:0] data;
        begin
            if (shared) begin
                pair_view = data;
            end else begin
                pair_view = view_upper(data[7:4]);
            end
        end
    endfunction

    // next value of one pair; the idle nibble of a split view never changes
    function [7:0] pair_next;
        input shared;
        input hit_full;
        input hit_nib;
        input [7:0] cur;
        input [7:0] wdata;
        begin
            pair_next = cur;
            if (hit_full) begin
                if (shared) begin
                    pair_next = wdata;
                end else begin
                    pair_next[7:4] = wdata[7:4];
                end
            end
            if (hit_nib && !shared) begin
                pair_next[3:0] = wdata[3:0];
            end
        end
    endfunction

    // per-group output data with its own trigger select
    generate
        for (g = 0; g < 4; g = g + 1) begin : grp
            pdr_group u_grp (
                .clk(CORE_CLK),
                .rst_n(NRST),
                .match_pulse(MATCH_PULSE), // R14
                .sel(ctrl_r[2*g+1:2*g]), // R12
                .wr_en(grp_wr[g]), // R04
                .wr_data(PWDATA[4*(g%2)+3:4*(g%2)]),
                .enable(enable_r[4*g+3:4*g]), // R02 R13
                .next_data(next_data_r[4*g+3:4*g]), // R03 R15
                .out_data(out_data[4*g+3:4*g]) // R01
            );
        end
    endgenerate

    assign out_high_wr = wr_acc & is_addr(PADDR, `PDR_ADDR_OUT_HIGH); // R04
    assign out_low_wr = wr_acc & is_addr(PADDR, `PDR_ADDR_OUT_LOW); // R04

    // both groups of a byte see the strobe; enabled bits drop it inside
    always @* begin
        grp_wr = 4'h0;
        if (out_low_wr) begin
            grp_wr[1:0] = 2'h3;
        end
        if (out_high_wr) begin
            grp_wr[3:2] = 2'h3;
        end
    end

    // next-data write decode, one pair of groups per pass
    generate
        for (p = 0; p < 2; p = p + 1) begin : pair
            wire shared_w;
            wire hit_full;
            wire hit_nib;
            assign shared_w = (p == 1) ? high_shared : low_shared; // R06
            assign hit_full = wr_acc &
                is_addr(PADDR, (p == 1) ? `PDR_ADDR_NEXT_HIGH : `PDR_ADDR_NEXT_LOW); // R07 R09
            assign hit_nib = wr_acc &
                is_addr(PADDR, (p == 1) ? `PDR_ADDR_NEXT_HIGH_LOWNIB : `PDR_ADDR_NEXT_LOW_LOWNIB); // R08 R10
            assign next_nxt[8*p+7:8*p] =
                pair_next(shared_w, hit_full, hit_nib, next_data_r[8*p+7:8*p], PWDATA[7:0]); // R11
        end
    endgenerate

    // output data and controls read back as stored
    assign rd_out_high = out_data[15:8];
    assign rd_out_low = out_data[7:0];
    assign rd_enable_high = enable_r[15:8];
    assign rd_enable_low = enable_r[7:0];
    assign rd_ctrl = ctrl_r;

    // next data follows the window of its pair
    assign rd_next_high = pair_view(high_shared, next_data_r[15:8]); // R07 R08 R11
    assign rd_next_high_nib = view_lower(next_data_r[11:8]); // R08 R11
    assign rd_next_low = pair_view(low_shared, next_data_r[7:0]); // R09 R10 R11
    assign rd_next_low_nib = view_lower(next_data_r[3:0]); // R10 R11

    always @* begin
        rdata_nxt = `PDR_WORD_ZERO;
        hit_nxt = 1'b1;
        case (PADDR)
            `PDR_ADDR_OUT_HIGH: begin
                rdata_nxt = pad_byte(rd_out_high);
            end

            `PDR_ADDR_OUT_LOW: begin
                rdata_nxt = pad_byte(rd_out_low);
            end

            `PDR_ADDR_NEXT_HIGH: begin
                rdata_nxt = pad_byte(rd_next_high); // R07
            end

            // the nibble window only exists while the pair is split
            `PDR_ADDR_NEXT_HIGH_LOWNIB: begin
                if (high_shared) begin
                    hit_nxt = 1'b0;
                end else begin
                    rdata_nxt = pad_byte(rd_next_high_nib); // R11
                end
            end

            `PDR_ADDR_NEXT_LOW: begin
                rdata_nxt = pad_byte(rd_next_low); // R09
            end

            `PDR_ADDR_NEXT_LOW_LOWNIB: begin
                if (low_shared) begin
                    hit_nxt = 1'b0;
                end else begin
                    rdata_nxt = pad_byte(rd_next_low_nib); // R11
                end
            end

            `PDR_ADDR_ENABLE_HIGH: begin
                rdata_nxt = pad_byte(rd_enable_high);
            end

            `PDR_ADDR_ENABLE_LOW: begin
                rdata_nxt = pad_byte(rd_enable_low);
            end

            `PDR_ADDR_CTRL: begin
                rdata_nxt = pad_byte(rd_ctrl);
            end

            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    // control register write strobes
    assign en_high_wr = wr_acc & is_addr(PADDR, `PDR_ADDR_ENABLE_HIGH);
    assign en_low_wr = wr_acc & is_addr(PADDR, `PDR_ADDR_ENABLE_LOW);
    assign ctrl_wr = wr_acc & is_addr(PADDR, `PDR_ADDR_CTRL);

    // setup cycle of any transfer
    assign setup_phase = PSEL & ~PENABLE;

    // next data, only moved by bus writes
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            next_data_r <= {`PDR_RST_DATA, `PDR_RST_DATA}; // R05
        end else begin
            next_data_r <= next_nxt;
        end
    end

    // per-bit pulse enables
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            enable_r <= {`PDR_RST_DATA, `PDR_RST_DATA};
        end else begin
            if (en_high_wr) begin
                enable_r[15:8] <= PWDATA[7:0];
            end
            if (en_low_wr) begin
                enable_r[7:0] <= PWDATA[7:0];
            end
        end
    end

    // trigger selects; reset puts every group on channel 3
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_r <= `PDR_RST_CTRL;
        end else if (ctrl_wr) begin
            ctrl_r <= PWDATA[7:0];
        end
    end

    // ready is registered in setup so the access needs no wait state
    always @* begin
        pready_nxt = setup_phase;
        pslverr_nxt = setup_phase & ~hit_nxt;
        prdata_nxt = PRDATA;
        if (rd_acc) begin
            prdata_nxt = rdata_nxt;
        end
    end

    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            PRDATA <= `PDR_WORD_ZERO;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= pready_nxt;
            PSLVERR <= pslverr_nxt;
            PRDATA <= prdata_nxt;
        end
    end

    // pins lag output data by one flop, all bits together
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            PULSE_OUT <= `PDR_RST_PINS;
        end else begin
            PULSE_OUT <= out_data; // R01 R15
        end
    end
endmodule

// file: design/pdr_regs.vh
`ifndef PDR_REGS_VH
`define PDR_REGS_VH
// byte addresses on APB
`define PDR_ADDR_OUT_HIGH 12'h000
`define PDR_ADDR_OUT_LOW 12'h004
`define PDR_ADDR_NEXT_HIGH 12'h008
`define PDR_ADDR_NEXT_HIGH_LOWNIB 12'h00C
`define PDR_ADDR_NEXT_LOW 12'h010
`define PDR_ADDR_NEXT_LOW_LOWNIB 12'h014
`define PDR_ADDR_ENABLE_HIGH 12'h018
`define PDR_ADDR_ENABLE_LOW 12'h01C
`define PDR_ADDR_CTRL 12'h020
// reset values
`define PDR_RST_DATA 8'h00
`define PDR_RST_CTRL 8'hFF
`define PDR_RST_NIB 4'h0
`define PDR_RST_PINS 16'h0000
// read value of an unused nibble
`define PDR_NIB_ONES 4'hF
`define PDR_BYTE_ZERO 8'h00
`define PDR_WORD_ZERO 32'h00000000
`define PDR_PAD_ZERO 24'h000000
`endif

// file: design/pdr_group.v
`timescale 1ns/1ps
`include "pdr_regs.vh"
module pdr_group (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // trigger source
    input wire [3:0] match_pulse,
    input wire [1:0] sel,
    // cpu side
    input wire wr_en,
    input wire [3:0] wr_data,
    input wire [3:0] enable,
    input wire [3:0] next_data,
    // output
    output reg [3:0] out_data
);
    integer i;
    wire fire;
    reg [3:0] out_nxt;

    assign fire = match_pulse[sel];

    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            if (enable[i]) begin
                out_nxt[i] = fire ? next_data[i] : out_data[i];
            end else begin
                out_nxt[i] = wr_en ? wr_data[i] : out_data[i];
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= `PDR_RST_NIB;
        end else begin
            out_data <= out_nxt;
        end
    end
endmodule

// file: dv/pdr_top_asserts.sv
`timescale 1ns/1ps
module pdr_top_asserts (
    // clock and reset
    input wire CORE_CLK,
    input wire NRST,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    // trigger and pins
    input wire [3:0] MATCH_PULSE,
    input wire [15:0] PULSE_OUT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_quiet;
        MATCH_PULSE == 4'h0 && !(PSEL && PENABLE && PWRITE);
    endsequence
    a_ready_first: assert property (s_setup |=> PREADY) else $error("no ready in access");
    a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
    a_rdata_pad: assert property (PRDATA[31:8] == 24'h000000) else $error("rdata pad");
    a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE) else $error("stray err");
    a_err_decode: assert property (PSEL && PENABLE && PADDR > 12'h020 |-> PSLVERR) else $error("no err");
    a_nib_ones: assert property (PSEL && PENABLE && !PWRITE && !PSLVERR && (PADDR == 12'h00C || PADDR == 12'h014)
        |-> PRDATA[7:4] == 4'hF) else $error("nibble not ones");
    // with no trigger and no write, pins must not move
    a_pins_hold: assert property (s_quiet |-> ##2 $stable(PULSE_OUT)) else $error("pins moved");
    a_reset_zero: assert property ($rose(NRST) |-> PULSE_OUT == 16'h0000) else $error("pins after reset");
endmodule
bind pdr_top pdr_top_asserts u_pdr_top_asserts (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MATCH_PULSE(MATCH_PULSE), .PULSE_OUT(PULSE_OUT));

// file: dv/pdr_timer_model.sv
`timescale 1ns/1ps
module pdr_timer_model (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // compare match, bit n for channel n
    output logic [3:0] match_pulse
);
    initial match_pulse = 4'h0;
    task automatic fire(input logic [1:0] ch);
        @(posedge clk);
        match_pulse <= 4'h1 << ch;
        @(posedge clk);
        match_pulse <= 4'h0;
    endtask
endmodule

// file: dv/pulse_output_data_regs_tb_top.sv
`timescale 1ns/1ps
`include "pdr_regs.vh"
module pulse_output_data_regs_tb_top;
    logic clk = 1'b0, nrst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] mp;
    logic [15:0] pout;
    int n_mismatch = 0, cmp_count = 0;
    initial forever #12.5 clk = ~clk;
    pdr_top u_pdr_top (.CORE_CLK(clk), .NRST(nrst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MATCH_PULSE(mp), .PULSE_OUT(pout));
    pdr_timer_model u_pdr_timer_model (.clk(clk), .rst_n(nrst_n), .match_pulse(mp));
    task automatic chk(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e, input logic err);
        apb(1'b0, a, 8'h00);
        chk("pslverr", {31'h0, err}, {31'h0, er});
        if (!err) chk("prdata", {24'h000000, e}, rd);
    endtask
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // the sequence needs a little over a hundred cycles
    initial begin
        #50000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst_n <= 1'b1;
        rc(`PDR_ADDR_OUT_HIGH, 8'h00, 1'b0);
        rc(`PDR_ADDR_OUT_LOW, 8'h00, 1'b0);
        rc(`PDR_ADDR_NEXT_HIGH, 8'h00, 1'b0);
        rc(`PDR_ADDR_NEXT_LOW, 8'h00, 1'b0);
        rc(`PDR_ADDR_CTRL, 8'hFF, 1'b0);
        rc(`PDR_ADDR_NEXT_HIGH_LOWNIB, 8'h00, 1'b1);
        rc(12'h0FC, 8'h00, 1'b1);
        apb(1'b1, 12'h0FC, 8'hFF);
        chk("wr_pslverr", 32'h00000001, {31'h0, er});
        apb(1'b1, `PDR_ADDR_OUT_LOW, 8'hA5);
        rc(`PDR_ADDR_OUT_LOW, 8'hA5, 1'b0);
        chk("pins", 32'h000000A5, {16'h0000, pout});
        apb(1'b1, `PDR_ADDR_ENABLE_LOW, 8'h0F);
        apb(1'b1, `PDR_ADDR_OUT_LOW, 8'h00);
        rc(`PDR_ADDR_OUT_LOW, 8'h05, 1'b0);
        apb(1'b1, `PDR_ADDR_NEXT_LOW, 8'h3C);
        rc(`PDR_ADDR_NEXT_LOW, 8'h3C, 1'b0);
        u_pdr_timer_model.fire(2'd3);
        rc(`PDR_ADDR_OUT_LOW, 8'h0C, 1'b0);
        // groups 3..0 on channels 3,2,1,0: both pairs split
        apb(1'b1, `PDR_ADDR_CTRL, 8'hE4);
        rc(`PDR_ADDR_NEXT_LOW, 8'h3F, 1'b0);
        apb(1'b1, `PDR_ADDR_NEXT_LOW_LOWNIB, 8'h56);
        rc(`PDR_ADDR_NEXT_LOW_LOWNIB, 8'hF6, 1'b0);
        rc(`PDR_ADDR_NEXT_LOW, 8'h3F, 1'b0);
        apb(1'b1, `PDR_ADDR_ENABLE_LOW, 8'hFF);
        apb(1'b1, `PDR_ADDR_ENABLE_HIGH, 8'hFF);
        apb(1'b1, `PDR_ADDR_NEXT_HIGH, 8'hA0);
        rc(`PDR_ADDR_NEXT_HIGH, 8'hAF, 1'b0);
        apb(1'b1, `PDR_ADDR_NEXT_HIGH_LOWNIB, 8'h05);
        rc(`PDR_ADDR_NEXT_HIGH_LOWNIB, 8'hF5, 1'b0);
        u_pdr_timer_model.fire(2'd1);
        rc(`PDR_ADDR_OUT_LOW, 8'h3C, 1'b0);
        u_pdr_timer_model.fire(2'd0);
        rc(`PDR_ADDR_OUT_LOW, 8'h36, 1'b0);
        u_pdr_timer_model.fire(2'd2);
        rc(`PDR_ADDR_OUT_HIGH, 8'h05, 1'b0);
        u_pdr_timer_model.fire(2'd3);
        rc(`PDR_ADDR_OUT_HIGH, 8'hA5, 1'b0);
        chk("pins", 32'h0000A536, {16'h0000, pout});
        apb(1'b1, `PDR_ADDR_OUT_HIGH, 8'h00);
        rc(`PDR_ADDR_OUT_HIGH, 8'hA5, 1'b0);
        print_verdict();
    end
endmodule
